// *** adc_serial_regs.svh ***
`ifndef ADC_SERIAL_REGS_SVH
`define ADC_SERIAL_REGS_SVH
// ----------------------------------------
// converter register map (serial address)
// ----------------------------------------
`define ADR_SOFT_RESET_AND_READBACK_CTRL 8'h00
`define ADR_SAMPLE_RATE_RANGE_CTRL       8'h20
`define ADR_POWER_DOWN_CTRL              8'h3f
`define ADR_OUTPUT_STANDARD_CTRL         8'h41
`define ADR_OUTPUT_CLOCK_POSITION_CTRL   8'h44
`define ADR_SAMPLE_ENCODING_CTRL         8'h50
`define ADR_USER_PATTERN_LOW             8'h51
`define ADR_USER_PATTERN_HIGH            8'h52
`define ADR_OFFSET_LOOP_ENABLE_CTRL      8'h53
`define ADR_GAIN_AND_OFFSET_LOOP_SPEED   8'h55
`define ADR_TEST_SEQUENCE_CTRL           8'h62
`define ADR_OFFSET_PEDESTAL_VALUE        8'h63
`define REG_COUNT                        12
`define REG_DEFAULT                      8'h00
`define SOFT_RESET_BIT                   7
`define READBACK_SEL_BIT                 0
`define WORD_BITS                        16
`define ADDR_BITS                        8
// ----------------------------------------
// controller registers (apb byte offsets)
// ----------------------------------------
`define CTL_CMD_OFS                      8'h00
`define CTL_STATUS_OFS                   8'h04
`define CTL_RDATA_OFS                    8'h08
`define CTL_HWRST_OFS                    8'h0c
`define CTL_STATUS_BUSY_BIT              0
// ----------------------------------------
// timing
// ----------------------------------------
`define MCLK_NS                          40
`define RST_PULSE_MIN_NS                 10
`define RST_PULSE_MAX_NS                 1000
`define SEN_DELAY_MIN_NS                 100
`define RST_PULSE_MIN_CYC  ((`RST_PULSE_MIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`define RST_PULSE_MAX_CYC  (`RST_PULSE_MAX_NS / `MCLK_NS)
`define RST_PULSE_CYC      ((`RST_PULSE_MIN_CYC + `RST_PULSE_MAX_CYC) / 2)
`define SEN_DELAY_CYC      ((`SEN_DELAY_MIN_NS + `MCLK_NS - 1) / `MCLK_NS)
`define SCLK_HALF_CYC                    4
`endif

// *** adc_serial_pkg.sv ***
package adc_serial_pkg;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [2:0] {
      IDLE, RST_PULSE, RST_WAIT, SETUP, CLK_HIGH, CLK_LOW, HOLD
   } ctl_state_e;
endpackage : adc_serial_pkg

// *** adc_serial_if.sv ***
interface adc_serial_if;
   logic serial_select_low;          // select, active low
   logic shiftClk;                   // shift clock
   logic serial_input_line;          // serial data into device
   logic overrange_or_readback_out;  // overrange or readback data
   logic hwResetPin;                 // hardware reset, active high

   modport device (
      input  serial_select_low,
      input  shiftClk,
      input  serial_input_line,
      input  hwResetPin,
      output overrange_or_readback_out
   );
   modport controller (
      output serial_select_low,
      output shiftClk,
      output serial_input_line,
      output hwResetPin,
      input  overrange_or_readback_out
   );
endinterface : adc_serial_if

// *** adc_serial_device.sv ***
`include "adc_serial_regs.svh"
// Summary of operation
// - capture input bit on falling clock edge
// - word is eight address, eight data bits
// - commit every sixteenth edge, drop partial words
// - readback mode blocks writes except readback bit
// - controller reads by sending the address
// - device shifts addressed register byte out
// - controller samples readback on falling edge
// - writing readback bit zero restores writes
// - pin is readback only in readback mode
// - soft reset bit restores defaults, self-clears
// - hardware reset pulse 10 ns to 1 us
// - wait 100 ns after reset before select
// - one write updates all fields together
module adc_serial_device (
   input  wire logic        mclk,          // system clock
   input  wire logic        reset,         // async reset, active high
   adc_serial_if.device     link,          // serial port pins
   input  wire logic        overrange,     // overrange flag from datapath
   output logic [95:0]      configOut,     // all registers, index*8
   output logic             readbackMode   // readback select state
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic selS1_r, selS2_r, clkS1_r, clkS2_r, clkS3_r;
   logic dinS1_r, dinS2_r, hwS1_r, hwS2_r;

   // two flops per pin, third flop for clock edge
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         selS1_r <= 1'b1;
         selS2_r <= 1'b1;
         clkS1_r <= 1'b1;
         clkS2_r <= 1'b1;
         clkS3_r <= 1'b1;
         dinS1_r <= 1'b0;
         dinS2_r <= 1'b0;
         hwS1_r  <= 1'b0;
         hwS2_r  <= 1'b0;
      end else begin
         selS1_r <= link.serial_select_low;
         selS2_r <= selS1_r;
         clkS1_r <= link.shiftClk;
         clkS2_r <= clkS1_r;
         clkS3_r <= clkS2_r;
         dinS1_r <= link.serial_input_line;
         dinS2_r <= dinS1_r;
         hwS1_r  <= link.hwResetPin;
         hwS2_r  <= hwS1_r;
      end
   end

   logic fallEdge;
   logic selActive;

   // falling shift clock edge (not gated by select), and select active
   assign fallEdge  = clkS3_r & ~clkS2_r;
   assign selActive = ~selS2_r;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // returns {mapped, index}
   function automatic logic [4:0] decode(input logic [7:0] a);
      logic [4:0] r;
      r = 5'h00;
      case (a)
         `ADR_SOFT_RESET_AND_READBACK_CTRL: r = 5'h10;
         `ADR_SAMPLE_RATE_RANGE_CTRL:       r = 5'h11;
         `ADR_POWER_DOWN_CTRL:              r = 5'h12;
         `ADR_OUTPUT_STANDARD_CTRL:         r = 5'h13;
         `ADR_OUTPUT_CLOCK_POSITION_CTRL:   r = 5'h14;
         `ADR_SAMPLE_ENCODING_CTRL:         r = 5'h15;
         `ADR_USER_PATTERN_LOW:             r = 5'h16;
         `ADR_USER_PATTERN_HIGH:            r = 5'h17;
         `ADR_OFFSET_LOOP_ENABLE_CTRL:      r = 5'h18;
         `ADR_GAIN_AND_OFFSET_LOOP_SPEED:   r = 5'h19;
         `ADR_TEST_SEQUENCE_CTRL:           r = 5'h1a;
         `ADR_OFFSET_PEDESTAL_VALUE:        r = 5'h1b;
         default:                           r = 5'h00;
      endcase
      return r;
   endfunction : decode

   // ----------------------------------------
   // shift and register state
   // ----------------------------------------
   adc_serial_pkg::reg_byte_t regs_r [`REG_COUNT];
   adc_serial_pkg::reg_byte_t regs_nxt [`REG_COUNT];
   logic [3:0]                bitCnt_r, bitCnt_nxt;
   logic [14:0]               shift_r, shift_nxt;
   logic [7:0]                rbShift_r, rbShift_nxt;
   logic                      pinOut_r, pinOut_nxt;

   logic [15:0] word;
   logic [4:0]  wDec;
   logic [4:0]  rDec;
   logic        rbSel;

   assign rbSel = regs_r[0][`READBACK_SEL_BIT];
   assign word  = {shift_r, dinS2_r};
   assign wDec  = decode(word[15:8]);
   assign rDec  = decode(word[7:0]);

   // next state of shifter, readback shifter and registers
   always_comb begin
      regs_nxt    = regs_r;
      bitCnt_nxt  = bitCnt_r;
      shift_nxt   = shift_r;
      rbShift_nxt = rbShift_r;
      if (hwS2_r) begin
         // hardware reset pin clears registers, bit counter and readback shifter
         for (int i = 0; i < `REG_COUNT; i++) begin
            regs_nxt[i] = `REG_DEFAULT;
         end
         bitCnt_nxt  = 4'h0;
         rbShift_nxt = 8'h00;
      end else if (!selActive) begin
         bitCnt_nxt = 4'h0;
      end else if (fallEdge) begin
         shift_nxt = word[14:0];
         if (bitCnt_r == 4'hf) begin
            bitCnt_nxt = 4'h0;
            if (rbSel) begin
               // only the readback bit may change
               if (wDec == 5'h10) begin
                  regs_nxt[0] = {7'h00, word[`READBACK_SEL_BIT]};
               end
            end else if (wDec == 5'h10 && word[`SOFT_RESET_BIT]) begin
               // soft reset; the bit itself is never kept high
               for (int i = 0; i < `REG_COUNT; i++) begin
                  regs_nxt[i] = `REG_DEFAULT;
               end
            end else if (wDec == 5'h10) begin
               regs_nxt[0] = {7'h00, word[`READBACK_SEL_BIT]};
            end else if (wDec[4]) begin
               regs_nxt[wDec[3:0]] = word[7:0];
            end
         end else begin
            bitCnt_nxt = bitCnt_r + 4'h1;
         end
         if (bitCnt_r == 4'h7) begin
            // address complete: load addressed byte for readback
            rbShift_nxt = rDec[4] ? regs_r[rDec[3:0]] : 8'h00;
         end else if (bitCnt_r >= 4'h8 && bitCnt_r <= 4'he) begin
            rbShift_nxt = {rbShift_r[6:0], 1'b0};
         end
      end
   end

   // shared pin select
   always_comb begin
      pinOut_nxt = overrange;
      if (rbSel) begin
         pinOut_nxt = rbShift_r[7];
      end
   end

   // register all state
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < `REG_COUNT; i++) begin
            regs_r[i] <= `REG_DEFAULT;
         end
         bitCnt_r  <= 4'h0;
         shift_r   <= 15'h0000;
         rbShift_r <= 8'h00;
         pinOut_r  <= 1'b0;
      end else begin
         regs_r    <= regs_nxt;
         bitCnt_r  <= bitCnt_nxt;
         shift_r   <= shift_nxt;
         rbShift_r <= rbShift_nxt;
         pinOut_r  <= pinOut_nxt;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // flatten register bank for the datapath
   always_comb begin
      configOut = 96'h0;
      for (int i = 0; i < `REG_COUNT; i++) begin
         configOut[i*8 +: 8] = regs_r[i];
      end
   end

   assign readbackMode                   = rbSel;
   assign link.overrange_or_readback_out = pinOut_r;
endmodule : adc_serial_device

// *** adc_serial_controller.sv ***
`include "adc_serial_regs.svh"
module adc_serial_controller #(
   parameter int SCLK_HALF = `SCLK_HALF_CYC  // mclk cycles per clock half
) (
   input  wire logic        mclk,      // system clock
   input  wire logic        reset,     // async reset, active high
   input  wire logic        psel,      // apb select
   input  wire logic        penable,   // apb enable
   input  wire logic        pwrite,    // apb direction
   input  wire logic [31:0] paddr,     // apb address
   input  wire logic [31:0] pwdata,    // apb write data
   output logic      [31:0] prdata,    // apb read data
   output logic             pready,    // apb ready
   output logic             pslverr,   // apb error
   adc_serial_if.controller link       // serial port pins
);
   if (SCLK_HALF < 4 || SCLK_HALF > 255) begin : g_bad_half
      $error("SCLK_HALF must lie in 4..255");
   end

   // ----------------------------------------
   // readback pin synchroniser
   // ----------------------------------------
   logic rbS1_r, rbS2_r;

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rbS1_r <= 1'b0;
         rbS2_r <= 1'b0;
      end else begin
         rbS1_r <= link.overrange_or_readback_out;
         rbS2_r <= rbS1_r;
      end
   end

   // ----------------------------------------
   // apb slave and sequencer
   // ----------------------------------------
   adc_serial_pkg::ctl_state_e state_r, state_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [3:0]  bitIdx_r, bitIdx_nxt;
   logic [15:0] cmd_r, cmd_nxt;
   logic [7:0]  rx_r, rx_nxt;
   logic [7:0]  rdata_r, rdata_nxt;
   logic        sel_r, sel_nxt, sclk_r, sclk_nxt, sdo_r, sdo_nxt, hw_r, hw_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt, perr_r, perr_nxt;
   logic        wrEn, busy;
   logic [7:0]  ofs;
   logic [7:0]  halfEnd;

   assign ofs     = paddr[7:0];
   assign busy    = (state_r != adc_serial_pkg::IDLE);
   assign wrEn    = psel & penable & pready_r & pwrite;
   assign halfEnd = 8'(SCLK_HALF - 1);

   // next state of bus answer and serial sequencer
   always_comb begin
      state_nxt  = state_r;
      cnt_nxt    = cnt_r + 8'h01;
      bitIdx_nxt = bitIdx_r;
      cmd_nxt    = cmd_r;
      rx_nxt     = rx_r;
      rdata_nxt  = rdata_r;
      sel_nxt    = sel_r;
      sclk_nxt   = sclk_r;
      sdo_nxt    = sdo_r;
      hw_nxt     = hw_r;
      prdata_nxt = 32'h0;
      pready_nxt = psel & ~penable;
      perr_nxt   = 1'b0;
      // setup cycle: prepare one-cycle access answer
      if (psel && !penable) begin
         unique case (ofs)
            `CTL_CMD_OFS:    prdata_nxt = {16'h0, cmd_r};
            `CTL_STATUS_OFS: prdata_nxt = {31'h0, busy};
            `CTL_RDATA_OFS:  prdata_nxt = {24'h0, rdata_r};
            `CTL_HWRST_OFS:  prdata_nxt = {31'h0, hw_r};
            default:         perr_nxt   = 1'b1;
         endcase
      end
      unique case (state_r)
         adc_serial_pkg::IDLE: begin
            cnt_nxt = 8'h00;
            if (wrEn && ofs == `CTL_CMD_OFS) begin
               cmd_nxt    = pwdata[15:0];
               state_nxt  = adc_serial_pkg::SETUP;
               sel_nxt    = 1'b0;
               sdo_nxt    = pwdata[15];
               bitIdx_nxt = 4'h0;
            end else if (wrEn && ofs == `CTL_HWRST_OFS && pwdata[0]) begin
               state_nxt = adc_serial_pkg::RST_PULSE;
               hw_nxt    = 1'b1;
            end
         end
         adc_serial_pkg::RST_PULSE: begin
            if (cnt_r == 8'(`RST_PULSE_CYC - 1)) begin
               hw_nxt    = 1'b0;
               cnt_nxt   = 8'h00;
               state_nxt = adc_serial_pkg::RST_WAIT;
            end
         end
         adc_serial_pkg::RST_WAIT: begin
            if (cnt_r == 8'(`SEN_DELAY_CYC - 1)) begin
               state_nxt = adc_serial_pkg::IDLE;
            end
         end
         adc_serial_pkg::SETUP, adc_serial_pkg::CLK_HIGH: begin
            if (cnt_r == halfEnd) begin
               sclk_nxt  = 1'b0;
               rx_nxt    = {rx_r[6:0], rbS2_r};
               cnt_nxt   = 8'h00;
               state_nxt = adc_serial_pkg::CLK_LOW;
            end
         end
         adc_serial_pkg::CLK_LOW: begin
            if (cnt_r == halfEnd) begin
               sclk_nxt = 1'b1;
               cnt_nxt  = 8'h00;
               if (bitIdx_r == 4'hf) begin
                  state_nxt = adc_serial_pkg::HOLD;
               end else begin
                  bitIdx_nxt = bitIdx_r + 4'h1;
                  sdo_nxt    = cmd_r[4'hf - bitIdx_nxt];
                  state_nxt  = adc_serial_pkg::CLK_HIGH;
               end
            end
         end
         adc_serial_pkg::HOLD: begin
            if (cnt_r == halfEnd) begin
               sel_nxt   = 1'b1;
               rdata_nxt = rx_r;
               state_nxt = adc_serial_pkg::IDLE;
            end
         end
      endcase
   end

   // register sequencer and bus answer
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r  <= adc_serial_pkg::IDLE;
         cnt_r    <= 8'h00;
         bitIdx_r <= 4'h0;
         cmd_r    <= 16'h0000;
         rx_r     <= 8'h00;
         rdata_r  <= 8'h00;
         sel_r    <= 1'b1;
         sclk_r   <= 1'b1;
         sdo_r    <= 1'b0;
         hw_r     <= 1'b0;
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         perr_r   <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         cnt_r    <= cnt_nxt;
         bitIdx_r <= bitIdx_nxt;
         cmd_r    <= cmd_nxt;
         rx_r     <= rx_nxt;
         rdata_r  <= rdata_nxt;
         sel_r    <= sel_nxt;
         sclk_r   <= sclk_nxt;
         sdo_r    <= sdo_nxt;
         hw_r     <= hw_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         perr_r   <= perr_nxt;
      end
   end

   assign prdata                 = prdata_r;
   assign pready                 = pready_r;
   assign pslverr                = perr_r;
   assign link.serial_select_low = sel_r;
   assign link.shiftClk          = sclk_r;
   assign link.serial_input_line = sdo_r;
   assign link.hwResetPin        = hw_r;
endmodule : adc_serial_controller

// *** adc_serial_asserts.sv ***
module adc_serial_asserts (
   input wire logic mclk,                      // system clock
   input wire logic reset,                     // async reset
   input wire logic serial_select_low,         // select, active low
   input wire logic shiftClk,                  // shift clock
   input wire logic serial_input_line,         // serial data in
   input wire logic overrange_or_readback_out, // device output
   input wire logic hwResetPin                 // hardware reset
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] edgeCnt_r;
   logic [4:0] edgeCnt_nxt;
   logic [5:0] hwCnt_r;
   logic [5:0] hwCnt_nxt;
   logic       clkPrev_r;
   // ----------------------------------------
   // helper counters
   // ----------------------------------------
   // falling edges per select window, reset pulse length
   always_comb begin
      edgeCnt_nxt = edgeCnt_r;
      if (serial_select_low)
         edgeCnt_nxt = 5'h00;
      else if (clkPrev_r && !shiftClk)
         edgeCnt_nxt = edgeCnt_r + 5'h01;
      hwCnt_nxt = hwResetPin ? hwCnt_r + 6'h01 : 6'h00;
   end
   // registers only
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         edgeCnt_r <= 5'h00;
         hwCnt_r <= 6'h00;
         clkPrev_r <= 1'b1;
      end else begin
         edgeCnt_r <= edgeCnt_nxt;
         hwCnt_r <= hwCnt_nxt;
         clkPrev_r <= shiftClk;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   property p_idle_high;
      serial_select_low |-> shiftClk;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("shift clock low while deselected");
   property p_sel_setup;
      $fell(serial_select_low) |-> shiftClk [*3];
   endproperty
   a_sel_setup: assert property (p_sel_setup)
      else $error("shift clock fell too soon after select");
   property p_data_hold;
      (!serial_select_low && $fell(shiftClk)) |-> $stable(serial_input_line);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("serial data moved at falling edge");
   property p_low_half;
      $fell(shiftClk) |-> !shiftClk [*4] ##1 shiftClk;
   endproperty
   a_low_half: assert property (p_low_half)
      else $error("shift clock low half not four cycles");
   property p_word_len;
      $rose(serial_select_low) |-> edgeCnt_r == 5'h10;
   endproperty
   a_word_len: assert property (p_word_len)
      else $error("select window not sixteen falling edges");
   property p_pulse_max;
      hwResetPin |-> hwCnt_r < 6'h19;
   endproperty
   a_pulse_max: assert property (p_pulse_max)
      else $error("hardware reset pulse too long");
   property p_pulse_min;
      $fell(hwResetPin) |-> hwCnt_r >= 6'h01;
   endproperty
   a_pulse_min: assert property (p_pulse_min)
      else $error("hardware reset pulse too short");
   property p_sel_after_rst;
      $fell(hwResetPin) |-> serial_select_low [*3];
   endproperty
   a_sel_after_rst: assert property (p_sel_after_rst)
      else $error("select too soon after hardware reset");
   property p_rst_no_sel;
      hwResetPin |-> serial_select_low;
   endproperty
   a_rst_no_sel: assert property (p_rst_no_sel)
      else $error("select active during hardware reset");
   c_frame: cover property ($rose(serial_select_low));
   c_rb_bit: cover property (!serial_select_low && overrange_or_readback_out);
   c_hw: cover property ($fell(hwResetPin));
endmodule : adc_serial_asserts

// *** tb_adc_serial_register_readback.sv ***
`include "adc_serial_regs.svh"
module tb_adc_serial_register_readback;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        overrange = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [95:0] configOut;
   logic        readbackMode;
   logic [31:0] rdv;
   logic        errv;
   int          errors = 0;
   int          num_checks = 0;
   logic [7:0]  expReg [12] = '{default: 8'h00};
   logic [7:0]  regAdr [12] = '{8'h00, 8'h20, 8'h3f, 8'h41, 8'h44, 8'h50,
                                8'h51, 8'h52, 8'h53, 8'h55, 8'h62, 8'h63};
   adc_serial_if link ();
   always #20 mclk = ~mclk;
   adc_serial_device u_adc_serial_device (.mclk(mclk), .reset(reset), .link(link),
      .overrange(overrange), .configOut(configOut), .readbackMode(readbackMode));
   adc_serial_controller #(.SCLK_HALF(4)) u_adc_serial_controller (.mclk(mclk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
   adc_serial_asserts u_adc_serial_asserts (.mclk(mclk), .reset(reset),
      .serial_select_low(link.serial_select_low), .shiftClk(link.shiftClk),
      .serial_input_line(link.serial_input_line), .hwResetPin(link.hwResetPin),
      .overrange_or_readback_out(link.overrange_or_readback_out));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task automatic check(input string what, input logic [31:0] ev, input logic [31:0] got);
      num_checks++;
      if (got !== ev) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, ev, got);
      end
   endtask : check
   // one apb transfer, waits for pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {24'h0, a};
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         errors++;
         results();
      end
      @(posedge mclk);
   endtask : apb
   // poll bit0 of a register until low, after first seeing it high if needHigh
   task automatic pollBit(input logic [7:0] a, input bit needHigh);
      bit seen;
      seen = !needHigh;
      for (int n = 0; n < 300; n++) begin
         apb(1'b0, a, 32'h0);
         if (rdv[0] === 1'b1) seen = 1;
         else if (seen && rdv[0] === 1'b0) return;
      end
      errors++;
      results();
   endtask : pollBit
   task automatic sendCmd(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, `CTL_CMD_OFS, {16'h0, a, d});
      pollBit(`CTL_STATUS_OFS, 1'b1);
   endtask : sendCmd
   task automatic checkRegs();
      for (int i = 0; i < 12; i++)
         check($sformatf("configOut %0d", i), {24'h0, expReg[i]}, {24'h0, configOut[i*8 +: 8]});
   endtask : checkRegs
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_apb_err();
      apb(1'b0, 8'h10, 32'h0);
      check("pslverr", 32'h1, {31'h0, errv});
      check("prdata", 32'h0, rdv);
   endtask : t_apb_err
   task automatic t_write();
      for (int i = 1; i < 12; i++) begin
         expReg[i] = 8'(i * 8'h13) ^ 8'h81;
         sendCmd(regAdr[i], expReg[i]);
      end
      sendCmd(8'h7e, 8'hff);
      checkRegs();
      apb(1'b0, `CTL_CMD_OFS, 32'h0);
      check("last command", 32'h00007eff, rdv);
      check("pslverr", 32'h0, {31'h0, errv});
   endtask : t_write
   task automatic t_pin();
      overrange <= 1'b1;
      repeat (3) @(posedge mclk);
      check("pin high", 32'h1, {31'h0, link.overrange_or_readback_out});
      overrange <= 1'b0;
      repeat (3) @(posedge mclk);
      check("pin low", 32'h0, {31'h0, link.overrange_or_readback_out});
   endtask : t_pin
   task automatic t_readback();
      sendCmd(8'h00, 8'h01);
      expReg[0] = 8'h01;
      check("readbackMode", 32'h1, {31'h0, readbackMode});
      overrange <= 1'b1;
      for (int i = 11; i >= 0; i--) begin
         sendCmd(regAdr[i], 8'h01);
         apb(1'b0, `CTL_RDATA_OFS, 32'h0);
         check($sformatf("readback %h", regAdr[i]), {24'h0, expReg[i]}, {24'h0, rdv[7:0]});
      end
      overrange <= 1'b0;
      checkRegs();
      sendCmd(8'h00, 8'h00);
      expReg[0] = 8'h00;
      check("readbackMode", 32'h0, {31'h0, readbackMode});
      expReg[2] = 8'h3c;
      sendCmd(8'h3f, 8'h3c);
      checkRegs();
   endtask : t_readback
   task automatic t_soft();
      sendCmd(8'h00, 8'h01);
      // soft reset bit is blocked while readback is on
      sendCmd(8'h00, 8'h81);
      expReg[0] = 8'h01;
      check("readbackMode", 32'h1, {31'h0, readbackMode});
      checkRegs();
      sendCmd(8'h00, 8'h00);
      sendCmd(8'h00, 8'h81);
      expReg = '{default: 8'h00};
      check("readbackMode", 32'h0, {31'h0, readbackMode});
      checkRegs();
   endtask : t_soft
   task automatic t_hw();
      expReg[1] = 8'h77;
      sendCmd(8'h20, 8'h77);
      apb(1'b1, `CTL_HWRST_OFS, 32'h1);
      pollBit(`CTL_HWRST_OFS, 1'b1);
      expReg = '{default: 8'h00};
      checkRegs();
      pollBit(`CTL_STATUS_OFS, 1'b0);
      expReg[11] = 8'h2a;
      sendCmd(8'h63, 8'h2a);
      checkRegs();
   endtask : t_hw
   // main sequence
   initial begin
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      checkRegs();
      t_apb_err();
      t_write();
      t_pin();
      t_readback();
      t_soft();
      t_hw();
      results();
   end
endmodule : tb_adc_serial_register_readback
